//--- logic/via_aggregator.sv
// Vectored interrupt aggregator: vector, port request and registers
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Function
// - all internal sources are ORed into one internal request line.
// - no external interrupt pins feed the internal request line; port pins feed the port line.
// - vector space has room for 127 non-zero vectors, few assigned.
// - vector register names the source behind the shared entry.
// - any write retires the vector and loads the next pending one.
// - vector bit 0 always reads zero.
// - vector reads zero when nothing is pending.
// - bits 3-1 hold source in group, bits 7-4 group, reset zero.
// - higher group number wins, group 4 highest.
// - sources within a group are served first come first served.
// - group priority encoder, group 4 (40h-46h) highest, group 1 (12h-16h) lowest.
// - endpoint and bus event vectors from 12h through 3Ch.
// - two-wire events 40h, 42h; endpoint-0 44h, 46h; rest reserved.
// - port-2 inputs are active low and ORed into the port request.
// - port request also feeds the wake-up logic.
// - select bit 0 picks the port-3 pin, 1 the port-2 inputs.
// - port path holds a delay set by a four-bit setting.
// - global enable zero blocks all; one lets each enable decide.
// - select register cleared only by power-up reset.
module via_aggregator
	import via_pkg::*;
(
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic func_rst_i,
	// Register port
	input wire logic [VIA_AW-1:0] reg_addr_i,
	input wire logic [VIA_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [VIA_DW-1:0] reg_rdata_o,
	// Internal sources
	input wire logic [VIA_NSRC-1:0] src_req_i,
	// Port pins
	input wire logic [7:0] port_two_inputs_n_i,
	input wire logic port_three_pin_three_n_i,
	// Core side
	output logic internal_irq_line_n_o,
	output logic port_irq_line_n_o,
	output logic internal_irq_take_o,
	output logic port_irq_take_o,
	output logic port_wake_o
);
	via_vstate_t state;
	logic [VIA_DW-1:0] vec;
	logic [VIA_NSRC-1:0] cur_sel;
	logic [VIA_NSRC-1:0] head_all;
	logic [VIA_NSRC-1:0] pend_all;
	logic [VIA_NSRC-1:0] clr_all;
	logic [VIA_NSRC-1:0] sel;
	logic wr_vec;
	logic port_sel;
	logic [VIA_DLY_W-1:0] dly_set;
	logic [VIA_DW-1:0] irq_en;
	logic [7:0] p2_meta;
	logic [7:0] p2_sync;
	logic p3_meta;
	logic p3_sync;
	logic port_src;
	logic port_dly;

	// Highest group among the group heads
	function automatic logic [VIA_NSRC-1:0] via_pick(
		input logic [VIA_NSRC-1:0] h);
		logic [3:0] best;
		best = 4'h0;
		via_pick = '0;
		for (int i = 0; i < VIA_NSRC; i++)
			if (h[i] && VIA_SRC_VEC[i][VIA_G_MSB:VIA_G_LSB] > best)
				best = VIA_SRC_VEC[i][VIA_G_MSB:VIA_G_LSB];
		for (int i = 0; i < VIA_NSRC; i++)
			via_pick[i] = h[i] &&
				(VIA_SRC_VEC[i][VIA_G_MSB:VIA_G_LSB] == best);
	endfunction : via_pick

	function automatic logic [VIA_DW-1:0] via_vec_of(
		input logic [VIA_NSRC-1:0] s);
		via_vec_of = VIA_VEC_NONE;
		for (int i = 0; i < VIA_NSRC; i++)
			if (s[i])
				via_vec_of = via_vec_of | VIA_SRC_VEC[i];
	endfunction : via_vec_of

	// Per-group arrival trackers
	for (genvar g = 0; g < VIA_NGRP; g++)
	begin : grp
		localparam int LO = VIA_GRP_LO[g];
		localparam int N = VIA_GRP_N[g];
		via_order_if #(.N(N)) oif ();
		assign oif.req = src_req_i[LO +: N];
		assign oif.clr = clr_all[LO +: N];
		assign oif.flush = func_rst_i;
		assign head_all[LO +: N] = oif.head;
		assign pend_all[LO +: N] = oif.pend;
		via_arrival_order #(.N(N)) u_order (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.port(oif)
		);
	end

	assign sel = via_pick(head_all);
	assign wr_vec = reg_wr_i && (reg_addr_i == VIA_ADDR_VECTOR);
	assign clr_all = (wr_vec && state == VIA_S_HOLD) ? cur_sel : '0;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= VIA_S_IDLE;
			vec <= VIA_VEC_NONE;
			cur_sel <= '0;
		end
		else if (func_rst_i)
		begin
			state <= VIA_S_IDLE;
			vec <= VIA_VEC_NONE;
			cur_sel <= '0;
		end
		else
		begin
			case (state)
				VIA_S_IDLE:
				begin
					if (|sel)
					begin
						vec <= via_vec_of(sel);
						cur_sel <= sel;
						state <= VIA_S_HOLD;
					end
				end
				VIA_S_HOLD:
				begin
					if (wr_vec)
					begin
						vec <= VIA_VEC_NONE;
						cur_sel <= '0;
						state <= VIA_S_IDLE;
					end
				end
				default:
				begin
					vec <= VIA_VEC_NONE;
					cur_sel <= '0;
					state <= VIA_S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			port_sel <= 1'b0;
		else if (reg_wr_i && reg_addr_i == VIA_ADDR_MCU_CFG)
			port_sel <= reg_wdata_i[VIA_XSEL_BIT];
	end

	// Delay setting and enables
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dly_set <= VIA_DLY_RST;
			irq_en <= VIA_EN_RST;
		end
		else if (func_rst_i)
		begin
			dly_set <= VIA_DLY_RST;
			irq_en <= VIA_EN_RST;
		end
		else if (reg_wr_i && reg_addr_i == VIA_ADDR_IRQ_CFG)
			dly_set <= reg_wdata_i[VIA_DLY_W-1:0];
		else if (reg_wr_i && reg_addr_i == VIA_ADDR_IRQ_EN)
			irq_en <= reg_wdata_i;
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= VIA_RD_ZERO;
		else if (!reg_rd_i)
			reg_rdata_o <= VIA_RD_ZERO;
		else
		begin
			case (reg_addr_i)
				VIA_ADDR_VECTOR:
					reg_rdata_o <= vec;
				VIA_ADDR_MCU_CFG:
					reg_rdata_o <= VIA_DW'(port_sel) << VIA_XSEL_BIT;
				VIA_ADDR_IRQ_CFG:
					reg_rdata_o <= VIA_DW'(dly_set);
				VIA_ADDR_IRQ_EN:
					reg_rdata_o <= irq_en;
				default:
					reg_rdata_o <= VIA_RD_ZERO;
			endcase
		end
	end

	// Port pin synchronisers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			p2_meta <= 8'hFF;
			p2_sync <= 8'hFF;
			p3_meta <= 1'b1;
			p3_sync <= 1'b1;
		end
		else
		begin
			p2_meta <= port_two_inputs_n_i;
			p2_sync <= p2_meta;
			p3_meta <= port_three_pin_three_n_i;
			p3_sync <= p3_meta;
		end
	end

	assign port_src = port_sel ? ~&p2_sync : ~p3_sync;

	via_port_delay u_delay (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i(port_src),
		.setting_i(dly_set),
		.req_o(port_dly)
	);

	// no external pin reaches the internal line; port pins drive the port line and wake
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			internal_irq_line_n_o <= 1'b1;
			port_irq_line_n_o <= 1'b1;
			port_wake_o <= 1'b0;
		end
		else
		begin
			internal_irq_line_n_o <= (vec == VIA_VEC_NONE);
			port_irq_line_n_o <= ~port_dly;
			port_wake_o <= port_dly;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			internal_irq_take_o <= 1'b0;
			port_irq_take_o <= 1'b0;
		end
		else
		begin
			internal_irq_take_o <= irq_en[VIA_EA_BIT] &&
				irq_en[VIA_EX0_BIT] && (vec != VIA_VEC_NONE);
			port_irq_take_o <= irq_en[VIA_EA_BIT] &&
				irq_en[VIA_EX1_BIT] && port_dly;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence vec_retire_s;
		state == VIA_S_HOLD && wr_vec && !func_rst_i;
	endsequence

	sequence vec_load_s;
		state == VIA_S_IDLE && (|sel) && !func_rst_i;
	endsequence

	vec_lsb_zero_a: assert property (!vec[VIA_LSB])
		else $error("vector bit 0 set");
	idle_vec_zero_a: assert property (
		state == VIA_S_IDLE |-> vec == VIA_VEC_NONE)
		else $error("idle vector not zero");
	line_follows_vec_a: assert property (
		##1 internal_irq_line_n_o == ($past(vec) == VIA_VEC_NONE))
		else $error("internal line disagrees with vector");
	retire_clears_a: assert property (
		vec_retire_s |=> vec == VIA_VEC_NONE
		##1 ((state == VIA_S_HOLD) == (|$past(sel)) || $past(func_rst_i)))
		else $error("retire did not reload next vector");
	top_group_wins_a: assert property (
		vec_load_s and (|pend_all[VIA_NSRC-1:VIA_GRP_LO[VIA_NGRP-1]])
		|=> vec[VIA_G_MSB:VIA_G_LSB] == VIA_GRP_TOP)
		else $error("lower group beat top group");
	level_rearm_a: assert property (
		vec_retire_s and (|(cur_sel & src_req_i))
		|=> |(pend_all & $past(cur_sel)))
		else $error("held request lost at retire");
	port_line_cause_a: assert property (
		!port_irq_line_n_o |-> $past(port_src, 2))
		else $error("port line without selected source");
	global_gate_a: assert property (
		internal_irq_take_o || port_irq_take_o
		|-> $past(irq_en[VIA_EA_BIT]))
		else $error("take without global enable");
	wake_match_a: assert property (
		port_wake_o == !port_irq_line_n_o)
		else $error("wake feed differs from port line");
endmodule : via_aggregator

//--- logic/via_pkg.sv
// Constants, register map and types of the vectored interrupt aggregator
package via_pkg;
	// Register port
	localparam int VIA_AW = 8;
	localparam int VIA_DW = 8;
	localparam logic [VIA_AW-1:0] VIA_ADDR_VECTOR = 8'h00;
	localparam logic [VIA_AW-1:0] VIA_ADDR_MCU_CFG = 8'h01;
	localparam logic [VIA_AW-1:0] VIA_ADDR_IRQ_CFG = 8'h02;
	localparam logic [VIA_AW-1:0] VIA_ADDR_IRQ_EN = 8'h03;
	// Field positions
	localparam int VIA_XSEL_BIT = 0;
	localparam int VIA_EX0_BIT = 0;
	localparam int VIA_EX1_BIT = 2;
	localparam int VIA_EA_BIT = 7;
	localparam int VIA_DLY_W = 4;
	localparam int VIA_G_MSB = 7;
	localparam int VIA_G_LSB = 4;
	localparam int VIA_LSB = 0;
	// Reset values
	localparam logic [VIA_DW-1:0] VIA_VEC_NONE = 8'h00;
	localparam logic [VIA_DW-1:0] VIA_RD_ZERO = 8'h00;
	localparam logic [VIA_DLY_W-1:0] VIA_DLY_RST = 4'h0;
	localparam logic [VIA_DW-1:0] VIA_EN_RST = 8'h00;
	// Sources, grouped by vector group
	localparam int VIA_NSRC = 17;
	localparam int VIA_NGRP = 4;
	localparam int VIA_GRP_LO [VIA_NGRP] = '{0, 3, 6, 13};
	localparam int VIA_GRP_N [VIA_NGRP] = '{3, 3, 7, 4};
	localparam logic [VIA_DW-1:0] VIA_SRC_VEC [VIA_NSRC] = '{
		8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
		8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A, 8'h3C,
		8'h40, 8'h42, 8'h44, 8'h46};
	localparam logic [3:0] VIA_GRP_TOP = 4'h4;
	// Port delay step
	localparam int VIA_CLK_NS = 4;
	localparam int VIA_TICK_NS = 1000;
	localparam int VIA_TICK_CYC = VIA_TICK_NS / VIA_CLK_NS;
	localparam int VIA_DIV_W = 8;
	// Vector states
	typedef enum logic [1:0] {
		VIA_S_IDLE = 2'b01,
		VIA_S_HOLD = 2'b10
	} via_vstate_t;
endpackage : via_pkg

//--- logic/via_order_if.sv
// Interface between the vector logic and one group's arrival tracker
`timescale 1ns/1ps
interface via_order_if #(parameter int N = 4);
	logic [N-1:0] req;
	logic [N-1:0] clr;
	logic flush;
	logic [N-1:0] pend;
	logic [N-1:0] head;
	modport order_side (input req, input clr, input flush,
		output pend, output head);
	modport ctrl_side (output req, output clr, output flush,
		input pend, input head);
endinterface : via_order_if

//--- logic/via_arrival_order.sv
// Pending flags and arrival order of the sources of one group
`timescale 1ns/1ps
module via_arrival_order #(parameter int N = 4)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Group port
	via_order_if.order_side port
);
	logic [N-1:0] arrive;
	logic older [N][N];

	assign arrive = port.req & (~port.pend | port.clr);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			port.pend <= '0;
		else if (port.flush)
			port.pend <= '0;
		else
			port.pend <= (port.pend & ~port.clr) | port.req;
	end

	for (genvar i = 0; i < N; i++)
	begin : row
		for (genvar j = 0; j < N; j++)
		begin : col
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					older[i][j] <= 1'b0;
				else if (arrive[i] && arrive[j])
					older[i][j] <= (i < j);
				else if (arrive[i])
					older[i][j] <= 1'b0;
				else if (arrive[j])
					older[i][j] <= 1'b1;
			end
		end
	end

	always_comb
	begin
		port.head = port.pend;
		for (int i = 0; i < N; i++)
			for (int j = 0; j < N; j++)
				if (i != j && port.pend[j] && older[j][i])
					port.head[i] = 1'b0;
	end
endmodule : via_arrival_order

//--- logic/via_port_delay.sv
// Programmable qualification delay of the port interrupt request
`timescale 1ns/1ps
module via_port_delay
	import via_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Request
	input wire logic raw_i,
	input wire logic [VIA_DLY_W-1:0] setting_i,
	output logic req_o
);
	logic [VIA_DIV_W-1:0] div;
	logic tick;
	logic [VIA_DLY_W-1:0] steps;

	// Step divider
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			div <= '0;
		else if (!raw_i || tick)
			div <= '0;
		else
			div <= div + 1'b1;
	end

	assign tick = (div == VIA_DIV_W'(VIA_TICK_CYC - 1));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			steps <= '0;
		else if (!raw_i)
			steps <= '0;
		else if (tick && steps != setting_i)
			steps <= steps + 1'b1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			req_o <= 1'b0;
		else
			req_o <= raw_i && (steps >= setting_i);
	end
endmodule : via_port_delay

//--- verification/via_core_model.sv
// Core model that services the internal interrupt line
`timescale 1ns/1ps
module via_core_model
	import via_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control and core inputs
	input wire logic svc_i,
	input wire logic take_i,
	input wire logic [VIA_DW-1:0] rdata_i,
	// Register port
	output logic [VIA_AW-1:0] addr_o,
	output logic [VIA_DW-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	// Serviced vector
	output logic [VIA_DW-1:0] vec_o,
	output logic got_o
);
	logic [1:0] st;
	logic [2:0] wt;
	assign addr_o = VIA_ADDR_VECTOR;
	assign wdata_o = 8'hA5;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= 2'h0;
			wt <= 3'h0;
			rd_o <= 1'b0;
			wr_o <= 1'b0;
			got_o <= 1'b0;
			vec_o <= 8'h00;
		end
		else
		begin
			rd_o <= 1'b0;
			wr_o <= 1'b0;
			got_o <= 1'b0;
			if (st == 2'h0 && svc_i && take_i)
			begin
				rd_o <= 1'b1;
				st <= 2'h1;
			end
			else if (st == 2'h1)
				st <= 2'h2;
			else if (st == 2'h2)
			begin
				vec_o <= rdata_i;
				got_o <= 1'b1;
				wr_o <= 1'b1;
				wt <= 3'h0;
				st <= 2'h3;
			end
			else if (st == 2'h3)
			begin
				wt <= wt + 3'h1;
				if (wt == 3'h4)
					st <= 2'h0;
			end
		end
	end
endmodule : via_core_model

//--- verification/via_aggregator_tb.sv
// Self-checking testbench of the vectored interrupt aggregator
`timescale 1ns/1ps
module via_aggregator_tb
	import via_pkg::*;
;
	logic clk_i, rst_i, func_rst_i, svc, got;
	logic tb_wr, tb_rd, p_wr, p_rd, line_n, pline_n, take, ptake, wake;
	logic [7:0] tb_addr, tb_wdata, p_addr, p_wdata, rdata, pvec, p2_n, rv;
	logic p3_n;
	logic [16:0] src;
	int n_mismatch, checks;
	logic [7:0] tbl [17] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
		8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A, 8'h3C,
		8'h40, 8'h42, 8'h44, 8'h46};
	via_aggregator u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.func_rst_i(func_rst_i),
		.reg_addr_i(svc ? p_addr : tb_addr),
		.reg_wdata_i(svc ? p_wdata : tb_wdata),
		.reg_wr_i(svc ? p_wr : tb_wr), .reg_rd_i(svc ? p_rd : tb_rd),
		.reg_rdata_o(rdata), .src_req_i(src),
		.port_two_inputs_n_i(p2_n), .port_three_pin_three_n_i(p3_n),
		.internal_irq_line_n_o(line_n), .port_irq_line_n_o(pline_n),
		.internal_irq_take_o(take), .port_irq_take_o(ptake),
		.port_wake_o(wake));
	via_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .svc_i(svc),
		.take_i(take), .rdata_i(rdata), .addr_o(p_addr),
		.wdata_o(p_wdata), .wr_o(p_wr), .rd_o(p_rd), .vec_o(pvec),
		.got_o(got));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic end_of_test();
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		tb_addr <= a;
		tb_wdata <= d;
		tb_wr <= 1'b1;
		@(posedge clk_i);
		tb_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		tb_addr <= a;
		tb_rd <= 1'b1;
		@(posedge clk_i);
		tb_rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		rd(a, rv);
		chk("register", e, rv);
	endtask : rdchk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic pulse(input int i);
		@(posedge clk_i);
		src[i] <= 1'b1;
		@(posedge clk_i);
		src[i] <= 1'b0;
	endtask : pulse
	task automatic svc_chk(input logic [7:0] e);
		int k;
		for (k = 0; k < 300 && got !== 1'b1; k++)
			cyc(1);
		if (got !== 1'b1)
		begin
			chk("service wait", 8'h01, {7'h00, got});
			end_of_test();
		end
		chk("serviced vector", e, pvec);
		chk("vector bit 0", 8'h00, {7'h00, pvec[0]});
		cyc(1);
	endtask : svc_chk
	task automatic t_reset();
		foreach (tbl[i])
			rdchk(8'(i % 4), 8'h00);
		rdchk(8'h10, 8'h00);
		wr(VIA_ADDR_VECTOR, 8'hFF);
		rdchk(VIA_ADDR_VECTOR, 8'h00);
		chk("lines", 8'h18, {3'h0, line_n, pline_n, wake, take, ptake});
	endtask : t_reset
	task automatic t_table();
		wr(VIA_ADDR_IRQ_EN, 8'h81);
		svc <= 1'b1;
		foreach (tbl[i])
		begin
			pulse(i);
			svc_chk(tbl[i]);
		end
		cyc(8);
		chk("idle line", 8'h01, {7'h00, line_n});
	endtask : t_table
	task automatic t_prio();
		svc <= 1'b0;
		@(posedge clk_i);
		src <= 17'h10001;
		@(posedge clk_i);
		src <= 17'h00000;
		cyc(5);
		chk("line on", 8'h00, {7'h00, line_n});
		pulse(12);
		cyc(2);
		pulse(6);
		pulse(13);
		svc <= 1'b1;
		svc_chk(8'h46);
		svc_chk(8'h40);
		svc_chk(8'h3C);
		svc_chk(8'h30);
		svc_chk(8'h12);
	endtask : t_prio
	task automatic t_level();
		svc <= 1'b0;
		wr(VIA_ADDR_IRQ_EN, 8'h01);
		@(posedge clk_i);
		src[15] <= 1'b1;
		cyc(6);
		chk("masked", 8'h00, {6'h00, line_n, take});
		wr(VIA_ADDR_IRQ_EN, 8'h80);
		cyc(3);
		chk("line gate", 8'h00, {7'h00, take});
		wr(VIA_ADDR_IRQ_EN, 8'h81);
		cyc(3);
		chk("taken", 8'h01, {7'h00, take});
		rdchk(VIA_ADDR_VECTOR, 8'h44);
		wr(VIA_ADDR_VECTOR, 8'h00);
		cyc(4);
		rdchk(VIA_ADDR_VECTOR, 8'h44);
		@(posedge clk_i);
		src[15] <= 1'b0;
		wr(VIA_ADDR_VECTOR, 8'h3C);
		cyc(4);
		rdchk(VIA_ADDR_VECTOR, 8'h00);
		chk("line off", 8'h01, {7'h00, line_n});
	endtask : t_level
	task automatic t_port();
		int k;
		wr(VIA_ADDR_IRQ_EN, 8'h84);
		@(posedge clk_i);
		p3_n <= 1'b0;
		cyc(6);
		chk("pin3", 8'h03, {5'h00, pline_n, wake, ptake});
		@(posedge clk_i);
		p3_n <= 1'b1;
		p2_n <= 8'hDF;
		cyc(8);
		chk("p2 unselected", 8'h01, {7'h00, pline_n});
		wr(VIA_ADDR_MCU_CFG, 8'h01);
		cyc(6);
		chk("p2 selected", 8'h00, {7'h00, pline_n});
		@(posedge clk_i);
		p2_n <= 8'hFF;
		wr(VIA_ADDR_IRQ_CFG, 8'h02);
		cyc(6);
		chk("p2 released", 8'h01, {7'h00, pline_n});
		@(posedge clk_i);
		p2_n <= 8'hFE;
		cyc(480);
		chk("delay hold", 8'h01, {7'h00, pline_n});
		for (k = 0; k < 40 && pline_n !== 1'b0; k++)
			cyc(1);
		chk("delay out", 8'h00, {7'h00, pline_n});
		if (pline_n !== 1'b0)
			end_of_test();
		@(posedge clk_i);
		p2_n <= 8'hFF;
	endtask : t_port
	task automatic t_func();
		@(posedge clk_i);
		func_rst_i <= 1'b1;
		@(posedge clk_i);
		func_rst_i <= 1'b0;
		rdchk(VIA_ADDR_MCU_CFG, 8'h01);
		rdchk(VIA_ADDR_IRQ_CFG, 8'h00);
		rdchk(VIA_ADDR_IRQ_EN, 8'h00);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(VIA_ADDR_MCU_CFG, 8'h00);
	endtask : t_func
	initial
	begin
		rst_i = 1'b1;
		func_rst_i = 1'b0;
		svc = 1'b0;
		tb_wr = 1'b0;
		tb_rd = 1'b0;
		tb_addr = 8'h00;
		tb_wdata = 8'h00;
		src = 17'h00000;
		p2_n = 8'hFF;
		p3_n = 1'b1;
		n_mismatch = 0;
		checks = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_table();
		t_prio();
		t_level();
		t_port();
		t_func();
		end_of_test();
	end
endmodule : via_aggregator_tb
